// File: hdl/tfsu_pkg.sv
// tfsu_pkg: shared constants and types for the tagged float stack unit
// assumes: both ends and the interface compile after this package
package tfsu_pkg;
  localparam int FRAC_W      = 59;
  localparam int EXP_W       = 13;
  localparam int STACK_DEPTH = 3;
  localparam int ADDR_W      = 32;
  localparam int MEM_W       = 64;
  localparam int SHAMT_W     = 6;
  localparam int MUL_STEP    = 3;
  localparam int DIV_STEP    = 2;
  localparam logic [5:0] MUL_CYCLES  = 6'h14;  // ceil(59/3)
  localparam logic [5:0] DIV_CYCLES  = 6'h1e;  // ceil(59/2)
  localparam logic [5:0] NORM_CYCLES = 6'h02;
  localparam logic [EXP_W-1:0] EXP_BIAS_S = 13'h007f;
  localparam logic [EXP_W-1:0] EXP_BIAS_D = 13'h03ff;

  typedef enum logic [3:0] {
    TFSU_OP_LOAD_S  = 4'h0,
    TFSU_OP_LOAD_D  = 4'h1,
    TFSU_OP_STORE_S = 4'h2,
    TFSU_OP_STORE_D = 4'h3,
    TFSU_OP_ADD     = 4'h4,
    TFSU_OP_SUB     = 4'h5,
    TFSU_OP_MUL     = 4'h6,
    TFSU_OP_DIV     = 4'h7
  } tfsu_op_t;

  typedef enum logic {
    TFSU_LEN_SINGLE = 1'b0,
    TFSU_LEN_DOUBLE = 1'b1
  } tfsu_len_t;

  typedef struct packed {
    tfsu_len_t              len;
    logic                   sign;
    logic [EXP_W-1:0]       exp;
    logic [FRAC_W-1:0]      frac;
  } tfsu_entry_t;
endpackage

// File: hdl/tfsu_if.sv
// tfsu_if: cpu to float unit issue and memory path
// assumes: single clock shared by cpu and float unit
`timescale 1ns/100ps
`default_nettype none
interface tfsu_if;
  logic                         issue_valid;
  tfsu_pkg::tfsu_op_t           issue_op;
  logic [tfsu_pkg::ADDR_W-1:0]  issue_addr;
  logic                         busy;
  logic                         mem_req;
  logic                         mem_we;
  logic [tfsu_pkg::ADDR_W-1:0]  mem_addr;
  logic [tfsu_pkg::MEM_W-1:0]   mem_wdata;
  logic                         mem_ack;
  logic [tfsu_pkg::MEM_W-1:0]   mem_rdata;

  modport unit (input issue_valid, issue_op, issue_addr, mem_ack, mem_rdata,
                output busy, mem_req, mem_we, mem_addr, mem_wdata);
  modport cpu (output issue_valid, issue_op, issue_addr, mem_ack, mem_rdata,
               input busy, mem_req, mem_we, mem_addr, mem_wdata);
endinterface
`default_nettype wire

// File: hdl/tfsu_cpu_end.sv
// tfsu_cpu_end: cpu-side issue port and memory responder for the unit
// assumes: user logic presents one instruction at a time, holds until taken
`timescale 1ns/100ps
`default_nettype none
module tfsu_cpu_end (
  input  wire logic                         clk,        // 40 MHz clock
  input  wire logic                         resetn,     // async, active low
  tfsu_if.cpu                               fpu,        // link to unit
  input  wire logic                         req_valid,  // user has an op
  input  wire tfsu_pkg::tfsu_op_t           req_op,     // op to issue
  input  wire logic [tfsu_pkg::ADDR_W-1:0]  req_addr,   // address from stack
  output logic                              req_taken,  // op handed over
  output logic                              cpu_stall,  // waiting on unit
  output logic                              mem_rd_req, // unit reads memory
  output logic                              mem_wr_req, // unit writes memory
  output logic [tfsu_pkg::ADDR_W-1:0]       mem_addr,   // memory address
  output logic [tfsu_pkg::MEM_W-1:0]        mem_wdata,  // store data
  input  wire logic                         mem_done,   // memory finished
  input  wire logic [tfsu_pkg::MEM_W-1:0]   mem_rdata   // load data
);
  // integer work goes on while unit busy; only a new issue waits
  assign fpu.issue_valid = req_valid & ~fpu.busy;
  assign fpu.issue_op    = req_op;
  assign fpu.issue_addr  = req_addr;
  assign req_taken       = req_valid & ~fpu.busy;
  assign cpu_stall       = req_valid & fpu.busy;
  assign mem_rd_req      = fpu.mem_req & ~fpu.mem_we;
  assign mem_wr_req      = fpu.mem_req & fpu.mem_we;
  assign mem_addr        = fpu.mem_addr;
  assign mem_wdata       = fpu.mem_wdata;
  assign fpu.mem_ack     = mem_done;
  assign fpu.mem_rdata   = mem_rdata;
endmodule
`default_nettype wire

// File: hdl/tfsu_unit.sv
// tfsu_unit: tagged float stack unit, runs beside the cpu
// assumes: cpu end only raises issue_valid while busy is low
// Operation
// - every stack entry carries length tag
// - tag set on load and on result
// - arithmetic precision comes from operand tags
// - single and double load/store groups
// - cpu forms address, unit fetches, pushes
// - cpu avoids overflow using memory temporaries
// - unit runs concurrently with integer cpu
// - cpu continues after starting long op
// - cpu stalls only when next needing unit
// - shift one cycle, normalize two cycles
// - multiply retires three bits per cycle
// - divide yields two quotient bits per cycle
// - fraction 59 bits, exponent 13 bits
// - shifter takes fraction and exponent amount
// - one logical microcode store sequences all
`timescale 1ns/100ps
`default_nettype none
module tfsu_unit (
  input  wire logic clk,       // 40 MHz clock
  input  wire logic resetn,    // async, active low
  tfsu_if.unit      cpu,       // issue and memory link
  output logic      idle       // unit has no work in hand
);
  localparam int FW = tfsu_pkg::FRAC_W;
  localparam int EW = tfsu_pkg::EXP_W;
  localparam int D  = tfsu_pkg::STACK_DEPTH;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_LOAD  = 7'b000_0010,
    ST_STORE = 7'b000_0100,
    ST_ALIGN = 7'b000_1000,
    ST_ITER  = 7'b001_0000,
    ST_NORM  = 7'b010_0000,
    ST_DONE  = 7'b100_0000
  } tfsu_state_t;

  // one logical store; upper bits steer fraction side, lower exponent side
  typedef struct packed {
    logic frac_add;
    logic frac_mul;
    logic frac_div;
    logic exp_add;
    logic exp_sub;
  } tfsu_uword_t;

  function automatic tfsu_uword_t tfsu_urom(input tfsu_pkg::tfsu_op_t op);
    tfsu_uword_t u;
    u = '0;
    case (op)
      tfsu_pkg::TFSU_OP_ADD: u.frac_add = 1'b1;
      tfsu_pkg::TFSU_OP_SUB: u.frac_add = 1'b1;
      tfsu_pkg::TFSU_OP_MUL: begin
        u.frac_mul = 1'b1;
        u.exp_add  = 1'b1;
      end
      tfsu_pkg::TFSU_OP_DIV: begin
        u.frac_div = 1'b1;
        u.exp_sub  = 1'b1;
      end
      default: u = '0;
    endcase
    return u;
  endfunction

  // leading zero count of the fraction, used by the normalizer
  function automatic logic [5:0] tfsu_lzc(input logic [FW-1:0] f);
    logic [5:0] n;
    logic       hit;
    n   = 6'(FW);
    hit = 1'b0;
    for (int i = FW - 1; i >= 0; i--) begin
      if (!hit && f[i]) begin
        n   = 6'(FW - 1 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction

  tfsu_state_t                    state, next_state;
  tfsu_pkg::tfsu_entry_t [D-1:0]  stk, next_stk;
  tfsu_pkg::tfsu_op_t             op, next_op;
  logic [tfsu_pkg::ADDR_W-1:0]    addr, next_addr;
  logic [FW-1:0]                  fa, next_fa;      // accumulator/remainder
  logic [FW-1:0]                  fb, next_fb;      // multiplicand/divisor
  logic [FW-1:0]                  fq, next_fq;      // multiplier/quotient
  logic [EW-1:0]                  ex, next_ex;
  logic                           sg, next_sg;
  tfsu_pkg::tfsu_len_t            rlen, next_rlen;
  logic [5:0]                     cnt, next_cnt;
  tfsu_uword_t                    uw, next_uw;
  logic [tfsu_pkg::MEM_W-1:0]     wdata, next_wdata;

  logic [EW-1:0]                  shamt;
  logic [FW-1:0]                  shifted;
  logic [FW+2:0]                  mpart;
  logic [FW:0]                    r1, r2;

  // single-cycle barrel shifter; amount is the exponent difference in align, the leading zero count in normalize
  assign shamt   = (state == ST_ALIGN) ? (ex) : EW'(tfsu_lzc(fa));
  assign shifted = (state == ST_ALIGN) ? (fb >> shamt) : (fa << shamt);

  assign idle         = (state == ST_IDLE);
  assign cpu.busy     = ~idle;
  assign cpu.mem_req  = (state == ST_LOAD) | (state == ST_STORE);
  assign cpu.mem_we   = (state == ST_STORE);
  assign cpu.mem_addr = addr;
  assign cpu.mem_wdata = wdata;

  always_comb begin
    next_state = state;
    next_stk   = stk;
    next_op    = op;
    next_addr  = addr;
    next_fa    = fa;
    next_fb    = fb;
    next_fq    = fq;
    next_ex    = ex;
    next_sg    = sg;
    next_rlen  = rlen;
    next_cnt   = cnt;
    next_uw    = uw;
    next_wdata = wdata;
    mpart      = '0;
    r1         = '0;
    r2         = '0;
    case (state)
      ST_IDLE: begin
        if (cpu.issue_valid) begin
          next_op   = cpu.issue_op;
          next_addr = cpu.issue_addr;
          next_uw   = tfsu_urom(cpu.issue_op);
          case (cpu.issue_op)
            tfsu_pkg::TFSU_OP_LOAD_S,
            tfsu_pkg::TFSU_OP_LOAD_D: next_state = ST_LOAD;
            tfsu_pkg::TFSU_OP_STORE_S,
            tfsu_pkg::TFSU_OP_STORE_D: begin
              // hidden bit sits at FW-2 and is dropped on the way out
              next_wdata = (cpu.issue_op == tfsu_pkg::TFSU_OP_STORE_D)
                ? {stk[0].sign, stk[0].exp[10:0], stk[0].frac[FW-3 -: 52]}
                : {32'h0000_0000, stk[0].sign, stk[0].exp[7:0],
                   stk[0].frac[FW-3 -: 23]};
              next_stk = {stk[0], stk[D-1:1]};
              next_state = ST_STORE;
            end
            default: begin
              // precision from the operand tags, not the opcode
              next_rlen = (stk[0].len == tfsu_pkg::TFSU_LEN_DOUBLE ||
                           stk[1].len == tfsu_pkg::TFSU_LEN_DOUBLE)
                          ? tfsu_pkg::TFSU_LEN_DOUBLE
                          : tfsu_pkg::TFSU_LEN_SINGLE;
              next_sg = stk[1].sign ^ stk[0].sign;
              if (next_uw.frac_add) begin
                // larger exponent into fa, align smaller via shifter
                if (stk[1].exp >= stk[0].exp) begin
                  next_fa = stk[1].frac;
                  next_fb = stk[0].frac;
                  next_ex = stk[1].exp - stk[0].exp;
                  next_sg = stk[1].sign;
                  next_cnt = {1'b0, stk[1].exp[4:0]};
                end else begin
                  next_fa = stk[0].frac;
                  next_fb = stk[1].frac;
                  next_ex = stk[0].exp - stk[1].exp;
                  next_sg = stk[0].sign ^
                            (cpu.issue_op == tfsu_pkg::TFSU_OP_SUB);
                  next_cnt = '0;
                end
                next_stk[1].exp = (stk[1].exp >= stk[0].exp) ? stk[1].exp
                                                              : stk[0].exp;
                next_state = ST_ALIGN;
              end else begin
                next_fa  = '0;
                next_fb  = stk[1].frac;
                next_fq  = stk[0].frac;
                next_ex  = next_uw.exp_add
                  ? stk[1].exp + stk[0].exp - EW'(tfsu_pkg::EXP_BIAS_D)
                  : stk[1].exp - stk[0].exp + EW'(tfsu_pkg::EXP_BIAS_D);
                next_cnt = next_uw.frac_mul ? tfsu_pkg::MUL_CYCLES
                                            : tfsu_pkg::DIV_CYCLES;
                if (next_uw.frac_div) begin
                  next_fa = stk[1].frac;
                  next_fb = stk[0].frac;
                  next_fq = '0;
                end
                next_state = ST_ITER;
              end
            end
          endcase
        end
      end
      ST_LOAD: if (cpu.mem_ack) begin
        // full stack push drops the bottom entry; cpu keeps depth
        next_stk = {stk[D-2:0], tfsu_pkg::tfsu_entry_t'('0)};
        if (op == tfsu_pkg::TFSU_OP_LOAD_D) begin
          next_stk[0].len  = tfsu_pkg::TFSU_LEN_DOUBLE;
          next_stk[0].sign = cpu.mem_rdata[63];
          next_stk[0].exp  = EW'(cpu.mem_rdata[62:52]);
          next_stk[0].frac = {1'b0, (cpu.mem_rdata[62:52] != 11'h000),
                              cpu.mem_rdata[51:0], 5'h00};
        end else begin
          next_stk[0].len  = tfsu_pkg::TFSU_LEN_SINGLE;
          next_stk[0].sign = cpu.mem_rdata[31];
          next_stk[0].exp  = EW'(cpu.mem_rdata[30:23]);
          next_stk[0].frac = {1'b0, (cpu.mem_rdata[30:23] != 8'h00),
                              cpu.mem_rdata[22:0], 34'h0_0000_0000};
        end
        next_state = ST_IDLE;
      end
      ST_STORE: if (cpu.mem_ack) next_state = ST_IDLE;
      ST_ALIGN: begin
        next_fb = shifted;
        next_fa = (op == tfsu_pkg::TFSU_OP_SUB) ? fa - shifted : fa + shifted;
        next_ex = stk[1].exp;
        next_cnt = tfsu_pkg::NORM_CYCLES;
        next_state = ST_NORM;
      end
      ST_ITER: begin
        if (uw.frac_mul) begin
          // three multiplier bits retired each cycle
          mpart   = {3'b000, fa} + (fq[0] ? {3'b000, fb}        : '0)
                  + (fq[1] ? {2'b00, fb, 1'b0}  : '0)
                  + (fq[2] ? {1'b0, fb, 2'b00}  : '0);
          next_fa = mpart[FW+2:3];
          next_fq = {mpart[2:0], fq[FW-1:3]};
        end else begin
          // restoring division, two quotient bits per cycle
          r1 = {fa, 1'b0} >= {1'b0, fb} ? {fa, 1'b0} - {1'b0, fb}
                                        : {fa, 1'b0};
          r2 = {r1[FW-1:0], 1'b0} >= {1'b0, fb}
               ? {r1[FW-1:0], 1'b0} - {1'b0, fb} : {r1[FW-1:0], 1'b0};
          next_fa = r2[FW-1:0];
          next_fq = {fq[FW-3:0], ({fa, 1'b0} >= {1'b0, fb}),
                     ({r1[FW-1:0], 1'b0} >= {1'b0, fb})};
        end
        next_cnt = cnt - 6'h01;
        if (cnt == 6'h01) begin
          if (uw.frac_div) next_fa = fq;
          next_cnt   = tfsu_pkg::NORM_CYCLES;
          next_state = ST_NORM;
        end
      end
      ST_NORM: begin
        // cycle one shifts by leading zeros and adjusts exponent, cycle two only counts down
        if (cnt == tfsu_pkg::NORM_CYCLES) begin
          next_fa = shifted;
          next_ex = ex - shamt;
        end
        next_cnt = cnt - 6'h01;
        if (cnt == 6'h01) next_state = ST_DONE;
      end
      ST_DONE: begin
        // pop two operands, push result with its length tag
        next_stk[0].len  = rlen;
        next_stk[0].sign = sg;
        next_stk[0].exp  = ex;
        next_stk[0].frac = fa;
        next_stk[1]      = stk[2];
        next_stk[2]      = '0;
        next_state       = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      stk   <= '0;
      op    <= tfsu_pkg::TFSU_OP_LOAD_S;
      addr  <= '0;
      fa    <= '0;
      fb    <= '0;
      fq    <= '0;
      ex    <= '0;
      sg    <= 1'b0;
      rlen  <= tfsu_pkg::TFSU_LEN_SINGLE;
      cnt   <= '0;
      uw    <= '0;
      wdata <= '0;
    end else begin
      state <= next_state;
      stk   <= next_stk;
      op    <= next_op;
      addr  <= next_addr;
      fa    <= next_fa;
      fb    <= next_fb;
      fq    <= next_fq;
      ex    <= next_ex;
      sg    <= next_sg;
      rlen  <= next_rlen;
      cnt   <= next_cnt;
      uw    <= next_uw;
      wdata <= next_wdata;
    end
  end
endmodule
`default_nettype wire

// File: dv/tfsu_monitor.sv
// tfsu_monitor: timing checks on the cpu to float unit link
// assumes: one clock, resetn asynchronous active low
`timescale 1ns/100ps
`default_nettype none
module tfsu_monitor (
  input wire logic                        clk,         // clock
  input wire logic                        resetn,      // reset, active low
  input wire logic                        issue_valid, // cpu offers op
  input wire tfsu_pkg::tfsu_op_t          issue_op,    // offered op
  input wire logic                        busy,        // unit working
  input wire logic                        mem_req,     // memory request
  input wire logic                        mem_we,      // write request
  input wire logic [tfsu_pkg::ADDR_W-1:0] mem_addr,    // memory address
  input wire logic                        mem_ack      // memory finished
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic arith;
  assign take = issue_valid && !busy;
  assign arith = issue_op[2];

  property p_take; take |=> busy; endproperty
  a_take: assert property (p_take)
    else $error("busy missing after take");
  property p_load; take && issue_op[3:1] == 3'h0 |=> mem_req && !mem_we;
  endproperty
  a_load: assert property (p_load)
    else $error("load gave no memory read");
  property p_store; take && issue_op[3:1] == 3'h1 |=> mem_req && mem_we;
  endproperty
  a_store: assert property (p_store)
    else $error("store gave no memory write");
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("memory request dropped before ack");
  property p_ack; mem_req && mem_ack |=> !busy && !mem_req; endproperty
  a_ack: assert property (p_ack)
    else $error("unit not idle after ack");
  property p_addsub; take && arith && !issue_op[1] |=> busy[*4] ##1 !busy;
  endproperty
  a_addsub: assert property (p_addsub)
    else $error("add or sub length wrong");
  property p_mul; take && issue_op == tfsu_pkg::TFSU_OP_MUL
    |=> busy ##22 busy ##1 !busy; endproperty
  a_mul: assert property (p_mul)
    else $error("multiply length wrong");
  property p_div; take && issue_op == tfsu_pkg::TFSU_OP_DIV
    |=> busy ##32 busy ##1 !busy; endproperty
  a_div: assert property (p_div)
    else $error("divide length wrong");
  property p_arith; take && arith |=> !mem_req; endproperty
  a_arith: assert property (p_arith)
    else $error("arithmetic touched memory");
  property p_idle; !busy |-> !mem_req; endproperty
  a_idle: assert property (p_idle)
    else $error("memory request while idle");
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// tb_top: both link ends joined, user sides driven and modelled
// assumes: tfsu_pkg, tfsu_if and both ends compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic               req_valid = 1'b0;
  tfsu_pkg::tfsu_op_t req_op = tfsu_pkg::TFSU_OP_LOAD_S;
  logic [31:0]        req_addr = 32'h0000_0000;
  logic               mem_done = 1'b0;
  logic [63:0]        mem_rdata = 64'h0000_0000_0000_0000;
  logic               req_taken, cpu_stall, mem_rd_req, mem_wr_req, idle;
  logic [31:0]        mem_addr;
  logic [63:0]        mem_wdata;
  int                 miscompares = 0;
  int                 n_compared = 0;
  logic [64:0]        stk[$];  // model stack: {double tag, memory image}
  always #12.5 clk = ~clk;
  tfsu_if bus ();
  tfsu_cpu_end i_tfsu_cpu_end (.clk(clk), .resetn(resetn), .fpu(bus),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_taken(req_taken), .cpu_stall(cpu_stall), .mem_rd_req(mem_rd_req),
    .mem_wr_req(mem_wr_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_done(mem_done), .mem_rdata(mem_rdata));
  tfsu_unit i_tfsu_unit (.clk(clk), .resetn(resetn), .cpu(bus), .idle(idle));
  tfsu_monitor i_tfsu_monitor (.clk(clk), .resetn(resetn),
    .issue_valid(bus.issue_valid), .issue_op(bus.issue_op), .busy(bus.busy),
    .mem_req(bus.mem_req), .mem_we(bus.mem_we), .mem_addr(bus.mem_addr),
    .mem_ack(bus.mem_ack));

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    miscompares++;
    $display("mismatch %s expected done seen timeout", what);
    final_report();
  endtask
  // offer op and hold it until taken; counts stalled cycles
  task automatic issue(input tfsu_pkg::tfsu_op_t op, input logic [31:0] a,
                       output int st);
    int i;
    st = 0;
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (req_taken === 1'b1) break;
      if (cpu_stall === 1'b1) st++;
    end
    if (i == 100) hang("issue");
    @(posedge clk);
  endtask
  // memory side: random latency, read data scrambled once released
  task automatic serve(input logic [31:0] a, input logic [63:0] rd,
                       output logic [63:0] wd);
    int i;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (mem_rd_req === 1'b1 || mem_wr_req === 1'b1) break;
    end
    if (i == 100) hang("memory request");
    check("mem_addr", {32'h0000_0000, mem_addr}, {32'h0000_0000, a});
    wd = mem_wdata;
    repeat ($urandom_range(3) + 1) @(posedge clk);
    mem_done <= 1'b1;
    mem_rdata <= rd;
    @(posedge clk);
    mem_done <= 1'b0;
    mem_rdata <= ~rd;
  endtask
  task automatic ld(input logic dbl, input logic [63:0] v);
    logic [31:0] a;
    logic [63:0] wd;
    int          s;
    a = $urandom;
    issue(tfsu_pkg::tfsu_op_t'({3'h0, dbl}), a, s);
    req_valid <= 1'b0;
    serve(a, v, wd);
    stk.push_front({dbl, dbl ? v : {32'h0000_0000, v[31:0]}});
    if (stk.size() > 3) void'(stk.pop_back());
  endtask
  task automatic sto(input logic dbl, input logic cmp, output int st);
    logic [31:0] a;
    logic [63:0] wd;
    logic [64:0] e;
    a = $urandom;
    e = stk.pop_front();
    issue(tfsu_pkg::tfsu_op_t'({3'h1, dbl}), a, st);
    req_valid <= 1'b0;
    serve(a, {$urandom, $urandom}, wd);
    if (cmp) check("store data", wd, e[63:0]);
  endtask

  initial begin
    tfsu_pkg::tfsu_op_t ops[4];
    int                 cyc[4];
    int                 i, s;
    ops = '{tfsu_pkg::TFSU_OP_ADD, tfsu_pkg::TFSU_OP_SUB,
            tfsu_pkg::TFSU_OP_MUL, tfsu_pkg::TFSU_OP_DIV};
    cyc = '{4, 4, 23, 33};
    void'($urandom(58));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 4; i++) ld(1'($urandom_range(1)), {$urandom, $urandom});
    for (i = 0; i < 3; i++) sto(stk[0][64], 1'b1, s);
    $display("test stack and tags done");
    foreach (ops[k]) begin
      ld(1'b0, {$urandom, $urandom});
      ld(1'b1, {$urandom, $urandom});
      void'(stk.pop_front());
      issue(ops[k], 32'h0000_0000, s);
      // store offered at once: held off only while the op runs
      sto(1'b1, 1'b0, s);
      check("stall", 64'(s), 64'(cyc[k]));
    end
    $display("test arithmetic timing done");
    ld(1'b1, {$urandom, $urandom});
    issue(tfsu_pkg::TFSU_OP_DIV, 32'h0000_0000, s);
    req_valid <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    check("idle", {63'h0, idle}, 64'h0000_0000_0000_0001);
    check("busy", {63'h0, bus.busy}, 64'h0000_0000_0000_0000);
    resetn <= 1'b1;
    stk.delete();
    @(posedge clk);
    ld(1'b0, {$urandom, $urandom});
    sto(1'b0, 1'b1, s);
    $display("test reset mid op done");
    final_report();
  end
endmodule
`default_nettype wire
